//--- dmac_chan.sv
// dma channel control/status, ping-pong buffers and burst sequencing
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
module dmac_chan #(
  parameter logic [dmac_pkg::DATA_W-1:0] RSV_BASE = dmac_pkg::RSV_BASE_DEF,
  parameter logic [dmac_pkg::DATA_W-1:0] RSV_MASK = dmac_pkg::RSV_MASK_DEF
) (
  // clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chan_rst,
  // avalon-mm slave
  input wire logic [dmac_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dmac_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [dmac_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // peripheral request
  input wire logic dev_req,
  // memory beat handshake
  output dmac_pkg::dmac_beat_s mem_beat,
  output logic mem_valid,
  input wire logic mem_ready,
  // channel interrupt
  output logic irq
);
  import dmac_pkg::*;

  // ---- reset and bus handshake ----
  logic rst_all;
  logic ack_r;
  logic ack_nxt;
  logic bus_req;
  logic wr_go;
  logic rd_load;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // any reset source clears the whole channel
  assign rst_all = sys_rst | chan_rst;

  // one wait state: ack rises the cycle after the request, then drops
  assign bus_req = avs_read | avs_write;
  assign ack_nxt = bus_req & ~ack_r;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign rd_load = avs_read & ~ack_r;
  assign avs_readdata = rdata_r;

  // ---- address decode ----
  logic hit_dev;
  logic hit_set;
  logic hit_clr;
  logic hit_ro;
  logic hit_a_addr;
  logic hit_a_cnt;
  logic hit_b_addr;
  logic hit_b_cnt;

  assign hit_dev = (avs_address == OFS_DEV_ADDR);
  assign hit_set = (avs_address == OFS_CSR_SET);
  assign hit_clr = (avs_address == OFS_CSR_CLR);
  assign hit_ro = (avs_address == OFS_CSR_RO);
  assign hit_a_addr = (avs_address == OFS_A_ADDR);
  assign hit_a_cnt = (avs_address == OFS_A_CNT);
  assign hit_b_addr = (avs_address == OFS_B_ADDR);
  assign hit_b_cnt = (avs_address == OFS_B_CNT);

  // ---- byte lane merge ----
  logic [DATA_W-1:0] be_mask;
  logic [CSR_W-1:0] wd8;
  logic set_wr;
  logic clr_wr;

  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd8 = avs_writedata[CSR_W-1:0];
  // csr bits live in lane 0 only, upper lanes are ignored
  assign set_wr = wr_go & hit_set & avs_byteenable[0];
  assign clr_wr = wr_go & hit_clr & avs_byteenable[0];

  // ---- control/status flags ----
  logic run_r;
  logic ie_r;
  logic err_r;
  logic done_a_r;
  logic start_a_r;
  logic done_b_r;
  logic start_b_r;
  logic biu_r;
  logic run_nxt;
  logic ie_nxt;
  logic err_nxt;
  logic done_a_nxt;
  logic start_a_nxt;
  logic done_b_nxt;
  logic start_b_nxt;
  logic biu_nxt;
  logic run_set;
  logic run_on;
  logic start_a_set;
  logic start_b_set;
  logic done_a_hw;
  logic done_b_hw;
  logic err_hw;
  logic [CSR_W-1:0] csr_view;

  assign run_set = set_wr & wd8[CSR_RUN];
  // start bits only launch while run is (or becomes) set
  assign run_on = run_r | run_set;
  assign start_a_set = set_wr & wd8[CSR_START_A] & run_on;
  assign start_b_set = set_wr & wd8[CSR_START_B] & run_on;

  // run and interrupt enable follow set and clear writes
  assign run_nxt = run_set ? 1'b1 : (clr_wr & wd8[CSR_RUN]) ? 1'b0 : run_r;
  assign ie_nxt = (set_wr & wd8[CSR_IE]) ? 1'b1 : (clr_wr & wd8[CSR_IE]) ? 1'b0 : ie_r;

  // error: hardware set wins over the clear by run
  assign err_nxt = err_hw ? 1'b1 : run_set ? 1'b0 : err_r;

  // done flags: completion wins; write one or a new start clears
  assign done_a_nxt = done_a_hw ? 1'b1 :
                      (start_a_set | (clr_wr & wd8[CSR_DONE_A])) ? 1'b0 : done_a_r;
  assign done_b_nxt = done_b_hw ? 1'b1 :
                      (start_b_set | (clr_wr & wd8[CSR_DONE_B])) ? 1'b0 : done_b_r;

  // start flags drop the moment their done flag rises
  assign start_a_nxt = done_a_hw ? 1'b0 : start_a_set ? 1'b1 :
                       (clr_wr & wd8[CSR_START_A]) ? 1'b0 : start_a_r;
  assign start_b_nxt = done_b_hw ? 1'b0 : start_b_set ? 1'b1 :
                       (clr_wr & wd8[CSR_START_B]) ? 1'b0 : start_b_r;

  // buffer in use flips on every completion, only reset clears it
  assign biu_nxt = (done_a_hw | done_b_hw) ? ~biu_r : biu_r;

  // interrupt is the or of the done and error bits, gated by enable
  assign irq = ie_r & (done_a_r | done_b_r | err_r);

  assign csr_view = {biu_r, start_b_r, done_b_r, start_a_r, done_a_r, err_r, ie_r, run_r};

  // flag registers
  always_ff @(posedge clk) begin
    if (rst_all) begin
      run_r <= 1'b0;
      ie_r <= 1'b0;
      err_r <= 1'b0;
      done_a_r <= 1'b0;
      start_a_r <= 1'b0;
      done_b_r <= 1'b0;
      start_b_r <= 1'b0;
      biu_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      ie_r <= ie_nxt;
      err_r <= err_nxt;
      done_a_r <= done_a_nxt;
      start_a_r <= start_a_nxt;
      done_b_r <= done_b_nxt;
      start_b_r <= start_b_nxt;
      biu_r <= biu_nxt;
    end
  end

  // ---- device address register ----
  logic [DATA_W-1:0] dev_addr_r;
  logic [DATA_W-1:0] dev_addr_nxt;
  logic dev_we;

  // locked while the channel runs
  assign dev_we = wr_go & hit_dev & ~run_r;
  assign dev_addr_nxt = dev_we ? ((dev_addr_r & ~be_mask) | (avs_writedata & be_mask))
                               : dev_addr_r;

  always_ff @(posedge clk) begin
    if (rst_all) begin
      dev_addr_r <= WORD_RST;
    end else begin
      dev_addr_r <= dev_addr_nxt;
    end
  end

  // ---- buffer contexts ----
  logic [DATA_W-1:0] a_addr;
  logic [DATA_W-1:0] b_addr;
  logic [CNT_W-1:0] a_cnt;
  logic [CNT_W-1:0] b_cnt;
  logic a_last;
  logic b_last;
  logic [DATA_W-1:0] a_addr_wd;
  logic [DATA_W-1:0] b_addr_wd;
  logic [DATA_W-1:0] a_cnt_wd;
  logic [DATA_W-1:0] b_cnt_wd;
  logic [CNT_W-1:0] step_bytes;
  logic step;
  logic step_a;
  logic step_b;

  // byte-enable merge against the current value
  assign a_addr_wd = (a_addr & ~be_mask) | (avs_writedata & be_mask);
  assign b_addr_wd = (b_addr & ~be_mask) | (avs_writedata & be_mask);
  assign a_cnt_wd = ({{(DATA_W-CNT_W){1'b0}}, a_cnt} & ~be_mask) | (avs_writedata & be_mask);
  assign b_cnt_wd = ({{(DATA_W-CNT_W){1'b0}}, b_cnt} & ~be_mask) | (avs_writedata & be_mask);

  // byte or half-word datum per beat
  assign step_bytes = dev_addr_r[DEV_DW] ? STEP_HALF : STEP_BYTE;
  assign step = mem_valid & mem_ready;
  assign step_a = step & ~biu_r;
  assign step_b = step & biu_r;

  dmac_buf_ctx u_buf_a (
    .clk(clk),
    .sys_rst(rst_all),
    .wr_addr(wr_go & hit_a_addr),
    .wr_cnt(wr_go & hit_a_cnt),
    .wr_data(hit_a_addr ? a_addr_wd : a_cnt_wd),
    .start(start_a_r),
    .step(step_a),
    .step_bytes(step_bytes),
    .addr_r(a_addr),
    .cnt_r(a_cnt),
    .last(a_last)
  );

  dmac_buf_ctx u_buf_b (
    .clk(clk),
    .sys_rst(rst_all),
    .wr_addr(wr_go & hit_b_addr),
    .wr_cnt(wr_go & hit_b_cnt),
    .wr_data(hit_b_addr ? b_addr_wd : b_cnt_wd),
    .start(start_b_r),
    .step(step_b),
    .step_bytes(step_bytes),
    .addr_r(b_addr),
    .cnt_r(b_cnt),
    .last(b_last)
  );

  // ---- burst sequencing ----
  dmac_state_e state_r;
  dmac_state_e state_nxt;
  logic act_start;
  logic [DATA_W-1:0] act_addr;
  logic act_last;
  logic addr_bad;
  logic burst_load;
  logic burst_last;
  logic [BEAT_W-1:0] burst_beats;
  logic go;
  dmac_beat_s beat_r;
  dmac_beat_s beat_nxt;

  // buffer in use picks the active buffer, also when both are started
  assign act_start = biu_r ? start_b_r : start_a_r;
  assign act_addr = biu_r ? b_addr : a_addr;
  assign act_last = biu_r ? b_last : a_last;

  // reserved space check; external memory holes are not flagged
  assign addr_bad = ((act_addr & RSV_MASK) == RSV_BASE);
  assign burst_beats = dev_addr_r[DEV_BS] ? BEATS_LONG : BEATS_SHORT;

  // new bursts start only while running, error free, and requested
  assign go = run_r & ~err_r & act_start & dev_req;
  assign burst_load = (state_r == ST_IDLE) & go;

  dmac_burst_ctr u_burst (
    .clk(clk),
    .sys_rst(rst_all),
    .load(burst_load),
    .beats(burst_beats),
    .step(step),
    .left_r(),
    .last(burst_last)
  );

  // next state; run is not looked at once a burst is under way
  always_comb begin
    state_nxt = state_r;
    err_hw = 1'b0;
    done_a_hw = 1'b0;
    done_b_hw = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (go) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (addr_bad) begin
          err_hw = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_BEAT;
        end
      end
      ST_BEAT: begin
        if (step) begin
          if (act_last) begin
            done_a_hw = ~biu_r;
            done_b_hw = biu_r;
            state_nxt = ST_IDLE;
          end else if (burst_last) begin
            state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_LOAD;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // beat fields captured before they are offered
  assign beat_nxt = (state_r == ST_LOAD) ?
                    dmac_beat_s'{addr: act_addr, dev_addr: dev_addr_r, to_mem: dev_addr_r[DEV_RW],
                      half: dev_addr_r[DEV_DW], big_end: dev_addr_r[DEV_E]} : beat_r;
  assign mem_valid = (state_r == ST_BEAT);
  assign mem_beat = beat_r;

  // sequencer registers
  always_ff @(posedge clk) begin
    if (rst_all) begin
      state_r <= ST_IDLE;
      beat_r <= '0;
    end else begin
      state_r <= state_nxt;
      beat_r <= beat_nxt;
    end
  end

  // ---- read data ----
  logic [DATA_W-1:0] csr_word;
  assign csr_word = {{(DATA_W-CSR_W){1'b0}}, csr_view};

  // unmapped offsets read zero
  assign rdata_nxt = !rd_load ? rdata_r :
                     hit_dev ? dev_addr_r :
                     (hit_set | hit_clr | hit_ro) ? csr_word :
                     hit_a_addr ? a_addr :
                     hit_a_cnt ? {{(DATA_W-CNT_W){1'b0}}, a_cnt} :
                     hit_b_addr ? b_addr :
                     hit_b_cnt ? {{(DATA_W-CNT_W){1'b0}}, b_cnt} : WORD_RST;

  // bus registers
  always_ff @(posedge clk) begin
    if (rst_all) begin
      ack_r <= 1'b0;
      rdata_r <= WORD_RST;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

endmodule

//--- dmac_pkg.sv
// constants, field layout and carrier types for the dma channel control block
// What this block does
// - Channel starts no burst unless the run bit, bit 0, is set.
// - Clearing run pauses; setting it again resumes from current pointer and buffer.
// - Run cleared mid-burst lets that burst finish before the pause.
// - Device address register takes writes only while run is zero.
// - Interrupt rises when enable bit 1 is set and any done or error is set.
// - Interrupt falls when enable is cleared or once both done bits and error are all clear.
// - Error bit 2 sets on reserved memory access, never on missing external memory.
// - Setting the run bit clears the error bit.
// - Buffer A done bit 3 sets on completion; cleared by write one or start.
// - Buffer B done bit 5 sets on completion; cleared by write one or start.
// - Buffer A start bit 4 launches buffer A only while run is set.
// - Buffer B start bit 6 launches buffer B only while run is set.
// - Hardware clears a buffer's start bit when it sets that buffer's done bit.
// - Buffer-in-use bit 7: zero means A, one means B; toggles on done.
// - Buffer-in-use clears on every reset source and nothing else.
// - With both start bits set, buffer-in-use picks the first buffer served.
// - Control/status bits 8 and above read zero and ignore writes.
// - Buffer address and count registers are writable only while their start bit is zero.
// - Each buffer count is a 13-bit byte count decremented as data moves.
package dmac_pkg;

  // register byte offsets on the avalon slave
  localparam int unsigned AVS_ADDR_W = 5;
  localparam logic [AVS_ADDR_W-1:0] OFS_DEV_ADDR = 5'h00;
  localparam logic [AVS_ADDR_W-1:0] OFS_CSR_SET = 5'h04;
  localparam logic [AVS_ADDR_W-1:0] OFS_CSR_CLR = 5'h08;
  localparam logic [AVS_ADDR_W-1:0] OFS_CSR_RO = 5'h0c;
  localparam logic [AVS_ADDR_W-1:0] OFS_A_ADDR = 5'h10;
  localparam logic [AVS_ADDR_W-1:0] OFS_A_CNT = 5'h14;
  localparam logic [AVS_ADDR_W-1:0] OFS_B_ADDR = 5'h18;
  localparam logic [AVS_ADDR_W-1:0] OFS_B_CNT = 5'h1c;

  // control/status bit positions
  localparam int unsigned CSR_W = 8;
  localparam int unsigned CSR_RUN = 0;
  localparam int unsigned CSR_IE = 1;
  localparam int unsigned CSR_ERR = 2;
  localparam int unsigned CSR_DONE_A = 3;
  localparam int unsigned CSR_START_A = 4;
  localparam int unsigned CSR_DONE_B = 5;
  localparam int unsigned CSR_START_B = 6;
  localparam int unsigned CSR_BIU = 7;

  // device address register fields
  localparam int unsigned DEV_RW = 0;
  localparam int unsigned DEV_E = 1;
  localparam int unsigned DEV_BS = 2;
  localparam int unsigned DEV_DW = 3;

  // widths, burst lengths and reset values
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 13;
  localparam int unsigned BEAT_W = 4;
  localparam logic [BEAT_W-1:0] BEATS_SHORT = 4'h4;
  localparam logic [BEAT_W-1:0] BEATS_LONG = 4'h8;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 4'h1;
  localparam logic [CNT_W-1:0] STEP_BYTE = 13'h0001;
  localparam logic [CNT_W-1:0] STEP_HALF = 13'h0002;
  localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RSV_BASE_DEF = 32'he000_0000;
  localparam logic [DATA_W-1:0] RSV_MASK_DEF = 32'hf000_0000;

  // one memory beat handed to the memory side
  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] dev_addr;
    logic to_mem;
    logic half;
    logic big_end;
  } dmac_beat_s;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_BEAT} dmac_state_e;

endpackage

//--- dmac_buf_ctx.sv
// one buffer's memory pointer and byte count
`timescale 1ns/100ps
module dmac_buf_ctx (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register writes, already merged with byte enables
  input wire logic wr_addr,
  input wire logic wr_cnt,
  input wire logic [dmac_pkg::DATA_W-1:0] wr_data,
  input wire logic start,
  // beat progress
  input wire logic step,
  input wire logic [dmac_pkg::CNT_W-1:0] step_bytes,
  // pointer state
  output logic [dmac_pkg::DATA_W-1:0] addr_r,
  output logic [dmac_pkg::CNT_W-1:0] cnt_r,
  output logic last
);
  import dmac_pkg::*;

  logic [DATA_W-1:0] addr_nxt;
  logic [CNT_W-1:0] cnt_nxt;
  logic addr_we;
  logic cnt_we;

  // writes only while the buffer is not started
  assign addr_we = wr_addr & ~start;
  assign cnt_we = wr_cnt & ~start;
  assign last = (cnt_r <= step_bytes);

  // pointer advances and count drains per beat
  assign addr_nxt = addr_we ? wr_data :
                    step ? addr_r + DATA_W'(step_bytes) : addr_r;
  assign cnt_nxt = cnt_we ? wr_data[CNT_W-1:0] :
                   step ? (last ? CNT_RST : cnt_r - step_bytes) : cnt_r;

  // state registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_r <= WORD_RST;
      cnt_r <= CNT_RST;
    end else begin
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

//--- dmac_burst_ctr.sv
// beats left in the current burst
`timescale 1ns/100ps
module dmac_burst_ctr (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [dmac_pkg::BEAT_W-1:0] beats,
  input wire logic step,
  // status
  output logic [dmac_pkg::BEAT_W-1:0] left_r,
  output logic last
);
  import dmac_pkg::*;

  logic [BEAT_W-1:0] left_nxt;

  // load on burst start, count down per beat
  assign last = (left_r == BEAT_LAST);
  assign left_nxt = load ? beats : (step & ~last) ? left_r - BEAT_LAST : left_r;

  // counter register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_r <= '0;
    end else begin
      left_r <= left_nxt;
    end
  end

endmodule

//--- dmac_chan_sva.sv
// concurrent checks on the dma channel ports
`timescale 1ns/100ps
module dmac_chan_sva (
  // clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chan_rst,
  // avalon-mm slave
  input wire logic [dmac_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dmac_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // peripheral and memory side
  input wire logic dev_req,
  input wire dmac_pkg::dmac_beat_s mem_beat,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire logic irq
);
  import dmac_pkg::*;
  // csr read completing, quiet link, status summary
  wire csr_sel = (avs_address == OFS_CSR_SET) || (avs_address == OFS_CSR_CLR) ||
    (avs_address == OFS_CSR_RO);
  wire csr_rd = avs_read && !avs_waitrequest && csr_sel;
  wire quiet = !mem_valid && !dev_req;
  wire any_st = avs_readdata[CSR_ERR] | avs_readdata[CSR_DONE_A] | avs_readdata[CSR_DONE_B];
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || chan_rst);
  // bus handshake steps
  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence req_ack;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  sequence beat_stall;
    mem_valid && !mem_ready;
  endsequence
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> req_wait)
    else $error("no wait state on new request");
  ack_next_a: assert property (req_wait |=> req_ack)
    else $error("request not answered after one wait state");
  beat_hold_a: assert property (beat_stall |=> mem_valid && $stable(mem_beat))
    else $error("beat dropped or changed before acceptance");
  beat_gap_a: assert property (mem_valid && mem_ready |=> !mem_valid)
    else $error("beat valid right after acceptance");
  beat_cause_a: assert property ($rose(mem_valid) |-> $past(dev_req, 2) || $past(mem_valid, 2))
    else $error("beat without request or running burst");
  irq_status_a: assert property (csr_rd && $past(quiet) && $past(quiet, 2) |->
    irq == (avs_readdata[CSR_IE] & any_st))
    else $error("interrupt disagrees with status");
  rsv_zero_a: assert property (csr_rd |-> avs_readdata[31:8] == 24'h0)
    else $error("reserved csr bits not zero");
  done_start_a: assert property (csr_rd |-> !(avs_readdata[CSR_DONE_A] && avs_readdata[CSR_START_A])
    && !(avs_readdata[CSR_DONE_B] && avs_readdata[CSR_START_B]))
    else $error("done and start set together");
  rst_clear_a: assert property (disable iff (1'h0) (sys_rst || chan_rst) |=> !irq && !mem_valid)
    else $error("reset left channel active");
endmodule

bind dmac_chan dmac_chan_sva dmac_chan_sva_i (.clk(clk), .sys_rst(sys_rst), .chan_rst(chan_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dev_req(dev_req),
  .mem_beat(mem_beat), .mem_valid(mem_valid), .mem_ready(mem_ready), .irq(irq));

//--- dmac_periph_mdl.sv
// peripheral request and memory acceptance model
`timescale 1ns/100ps
module dmac_periph_mdl (
  // clock
  input wire logic clk,
  // bench control
  input wire logic req_on,
  input wire logic slow,
  // channel side
  input wire logic mem_valid,
  input wire dmac_pkg::dmac_beat_s mem_beat,
  output logic dev_req,
  output logic mem_ready,
  // accepted beats
  output logic [15:0] beats,
  output logic [31:0] last_addr
);
  import dmac_pkg::*;
  initial begin
    dev_req = 1'h0;
    mem_ready = 1'h0;
    beats = 16'h0;
    last_addr = 32'h0;
  end
  // level request, ready with one stall per beat when slow
  always @(posedge clk) begin
    dev_req <= req_on;
    mem_ready <= slow ? (mem_valid && !mem_ready) : 1'h1;
    if (mem_valid && mem_ready) begin
      beats <= beats + 16'h1;
      last_addr <= mem_beat.addr;
    end
  end
endmodule

//--- dma_channel_double_buffer_control_test.sv
// self-checking bench for the dma channel control block
`timescale 1ns/100ps
module dma_channel_double_buffer_control_test;
  import dmac_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic chan_rst = 1'h0;
  logic [AVS_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic dev_req;
  logic mem_valid;
  logic mem_ready;
  logic irq;
  dmac_beat_s mem_beat;
  logic req_on = 1'h0;
  logic slow = 1'h0;
  logic [15:0] beats;
  logic [31:0] last_addr;
  int n_errors = 0;
  int n_tests = 0;
  // 20 mhz clock
  always #25 clk = ~clk;
  dmac_chan dmac_chan_i (.clk(clk), .sys_rst(sys_rst), .chan_rst(chan_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dev_req(dev_req), .mem_beat(mem_beat),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .irq(irq));
  dmac_periph_mdl dmac_periph_mdl_i (.clk(clk), .req_on(req_on), .slow(slow),
    .mem_valid(mem_valid), .mem_beat(mem_beat), .dev_req(dev_req), .mem_ready(mem_ready),
    .beats(beats), .last_addr(last_addr));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic irq_chk(input logic exp);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic wait_beats(input logic [15:0] n);
    while (beats !== n) @(posedge clk);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd_chk(5'(i * 4), 32'h0);
    rd_chk(5'h02, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_norun;
    wr(OFS_DEV_ADDR, 32'h0000_0008);
    rd_chk(OFS_DEV_ADDR, 32'h0000_0008);
    wr(OFS_DEV_ADDR, 32'h0000_0000);
    wr(OFS_CSR_SET, 32'h0000_0010);
    rd_chk(OFS_CSR_RO, 32'h0);
    req_on <= 1'h1;
    repeat (20) @(posedge clk);
    chk({16'h0, beats}, 32'h0);
    req_on <= 1'h0;
    $display("t_norun done");
  endtask
  task automatic t_pingpong;
    wr(OFS_A_ADDR, 32'h0000_0100);
    wr(OFS_A_CNT, 32'h0000_0004);
    wr(OFS_B_ADDR, 32'h0000_0200);
    wr(OFS_B_CNT, 32'h0000_0004);
    wr(OFS_CSR_SET, 32'h0000_0053);
    req_on <= 1'h1;
    wait_beats(16'h1);
    chk(last_addr, 32'h0000_0100);
    wait_beats(16'h8);
    chk(last_addr, 32'h0000_0203);
    req_on <= 1'h0;
    repeat (3) @(posedge clk);
    rd_chk(OFS_CSR_RO, 32'h0000_002b);
    chk({31'h0, irq}, 32'h1);
    rd_chk(OFS_A_ADDR, 32'h0000_0104);
    rd_chk(OFS_A_CNT, 32'h0);
    wr(OFS_CSR_CLR, 32'h0000_0008);
    irq_chk(1'h1);
    wr(OFS_CSR_CLR, 32'h0000_0020);
    irq_chk(1'h0);
    $display("t_pingpong done");
  endtask
  task automatic t_locked;
    wr(OFS_DEV_ADDR, 32'h0000_000c);
    rd_chk(OFS_DEV_ADDR, 32'h0);
    wr(OFS_A_CNT, 32'h0000_0008);
    wr(OFS_CSR_SET, 32'hffff_ff10);
    wr(OFS_A_ADDR, 32'h0000_0999);
    rd_chk(OFS_A_ADDR, 32'h0000_0104);
    wr(OFS_CSR_RO, 32'h0000_00ff);
    rd_chk(OFS_CSR_SET, 32'h0000_0013);
    $display("t_locked done");
  endtask
  task automatic t_pause;
    slow <= 1'h1;
    req_on <= 1'h1;
    wait_beats(16'h9);
    wr(OFS_CSR_CLR, 32'h0000_0001);
    repeat (40) @(posedge clk);
    chk({16'h0, beats}, 32'h0000_000c);
    rd_chk(OFS_CSR_RO, 32'h0000_0012);
    wr(OFS_CSR_SET, 32'h0000_0001);
    wait_beats(16'h10);
    chk(last_addr, 32'h0000_010b);
    req_on <= 1'h0;
    slow <= 1'h0;
    repeat (3) @(posedge clk);
    rd_chk(OFS_CSR_RO, 32'h0000_008b);
    wr(OFS_CSR_SET, 32'h0000_0010);
    rd_chk(OFS_CSR_RO, 32'h0000_0093);
    wr(OFS_CSR_CLR, 32'h0000_0010);
    rd_chk(OFS_CSR_RO, 32'h0000_0083);
    $display("t_pause done");
  endtask
  task automatic t_error;
    wr(OFS_B_ADDR, 32'he000_0010);
    wr(OFS_B_CNT, 32'h0000_0004);
    wr(OFS_CSR_SET, 32'h0000_0040);
    req_on <= 1'h1;
    repeat (20) @(posedge clk);
    chk({16'h0, beats}, 32'h0000_0010);
    req_on <= 1'h0;
    repeat (3) @(posedge clk);
    rd_chk(OFS_CSR_RO, 32'h0000_00c7);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_CSR_SET, 32'h0000_0001);
    rd_chk(OFS_CSR_RO, 32'h0000_00c3);
    $display("t_error done");
  endtask
  task automatic t_rst;
    @(posedge clk);
    chan_rst <= 1'h1;
    @(posedge clk);
    chan_rst <= 1'h0;
    rd_chk(OFS_CSR_RO, 32'h0);
    $display("t_rst done");
  endtask
  // half-word, eight-beat, device-to-memory, big-endian buffer; run cleared after first beat, burst still completes
  task automatic t_wide;
    wr(OFS_DEV_ADDR, 32'h0000_000f);
    wr(OFS_A_ADDR, 32'h0000_0300);
    wr(OFS_A_CNT, 32'h0000_0010);
    wr(OFS_CSR_SET, 32'h0000_0011);
    req_on <= 1'h1;
    wait_beats(16'h11);
    wr(OFS_CSR_CLR, 32'h0000_0001);
    req_on <= 1'h0;
    repeat (20) @(posedge clk);
    chk({16'h0, beats}, 32'h0000_0018);
    chk(last_addr, 32'h0000_030e);
    chk(mem_beat.dev_addr, 32'h0000_000f);
    chk({29'h0, mem_beat.to_mem, mem_beat.half, mem_beat.big_end}, 32'h7);
    rd_chk(OFS_CSR_RO, 32'h0000_0088);
    $display("t_wide done");
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    t_reset;
    t_norun;
    t_pingpong;
    t_locked;
    t_pause;
    t_error;
    t_rst;
    t_wide;
    finish_test;
  end
  // watchdog
  initial begin
    #(20000 * 50);
    n_errors++;
    finish_test;
  end
endmodule
